// file: lcr_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH

// ***********************************
// register offsets
// ***********************************
`define LCR_OFS_COLOR_CTRL    8'h00
`define LCR_OFS_TINT_LUMA     8'h01
`define LCR_OFS_CUR_LIMITS    8'h02
`define LCR_OFS_WHITE_CTRL    8'h03
`define LCR_OFS_MAIN_CUR      8'h04
`define LCR_OFS_SUB_CUR       8'h05
`define LCR_OFS_PIN_DIR       8'h06
`define LCR_OFS_PIN_DATA      8'h07
`define LCR_OFS_POWER_EN      8'h08

// ***********************************
// writable bit masks
// ***********************************
`define LCR_WM_COLOR_CTRL     8'hee
`define LCR_WM_FULL           8'hff
`define LCR_WM_CUR_LIMITS     8'h3f
`define LCR_WM_WHITE_CTRL     8'h3f
`define LCR_WM_PIN_DIR        8'h17
`define LCR_WM_PIN_DATA       8'h07
`define LCR_WM_POWER_EN       8'h6c

// ***********************************
// reset values
// ***********************************
`define LCR_RST_COLOR_CTRL    8'h20
`define LCR_RST_POWER_EN      8'h04
`define LCR_RST_ZERO          8'h00

// ***********************************
// field positions
// ***********************************
`define LCR_B_PWM_EN          7
`define LCR_B_MASTER_EN       6
`define LCR_B_OUT_TYPE        5
`define LCR_B_RED_EN          3
`define LCR_B_GREEN_EN        2
`define LCR_B_BLUE_EN         1
`define LCR_B_SAFETY          7
`define LCR_B_FADE_LONG       5
`define LCR_B_FADE_SUB        4
`define LCR_B_FADE_EN         3
`define LCR_B_GANG            2
`define LCR_B_MAIN_EN         1
`define LCR_B_SUB_EN          0
`define LCR_B_EXT_PWM_EN      4
`define LCR_B_ACTIVE          6
`define LCR_B_BOOST           5
`define LCR_B_FLASH           3
`define LCR_B_LOAD            2

// ***********************************
// timing
// ***********************************
`define LCR_CLK_MHZ           250
`define LCR_FADE_SHORT_US     650000
`define LCR_FADE_LONG_US      1300000
`define LCR_FADE_STEPS        255
`define LCR_FADE_SHORT_CYC    ((`LCR_FADE_SHORT_US * `LCR_CLK_MHZ) / `LCR_FADE_STEPS)
`define LCR_FADE_LONG_CYC     ((`LCR_FADE_LONG_US * `LCR_CLK_MHZ) / `LCR_FADE_STEPS)
`define LCR_FADE_CNT_W        21

`endif

// file: lcr_pkg.sv
// state types of the lighting control register bank
`include "lcr_defs.svh"
package lcr_pkg;

  typedef enum logic {LCR_FADE_IDLE, LCR_FADE_RAMP} lcr_fade_e;

  typedef struct packed {
    lcr_fade_e                   st;
    logic [`LCR_FADE_CNT_W-1:0]  cnt;
    logic [7:0]                  level;
  } lcr_fade_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] slot;
    logic [2:0] pwm;
  } lcr_pwm_s;

  typedef struct packed {
    logic [7:0] color_ctrl;
    logic [7:0] tint_luma;
    logic [7:0] cur_limits;
    logic [7:0] white_ctrl;
    logic [7:0] main_cur;
    logic [7:0] sub_cur;
    logic [7:0] pin_dir;
    logic [7:0] pin_data;
    logic [7:0] power_en;
    logic [7:0] rdata;
    logic       rvalid;
    logic [2:0] led;
    logic [2:0] gpio_out;
    logic [2:0] gpio_oe;
    logic [7:0] main_code;
    logic [7:0] sub_code;
    logic       ext_gate;
  } lcr_top_s;

endpackage

// file: lcr_color_pwm.sv
// internal colour pwm pattern generator
`timescale 1ns/1ps
`default_nettype none
module lcr_color_pwm (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] tint,
  input  wire logic [2:0] luminance_level,
  input  wire logic       overlap_mode,
  output logic      [2:0] pwm
);
  import lcr_pkg::*;

  lcr_pwm_s s_r;
  lcr_pwm_s s_nxt;

  // bit 2 red, bit 1 green, bit 0 blue; upper codes all give white
  function automatic logic [2:0] tint_mix(input logic [3:0] t);
    unique case (t)
      4'h0:    tint_mix = 3'h4;
      4'h1:    tint_mix = 3'h2;
      4'h2:    tint_mix = 3'h1;
      4'h3:    tint_mix = 3'h6;
      4'h4:    tint_mix = 3'h3;
      4'h5:    tint_mix = 3'h5;
      default: tint_mix = 3'h7;
    endcase
  endfunction

  always_comb begin
    logic       duty_on;
    logic [2:0] slot_sel;
    duty_on  = 1'b0;
    slot_sel = 3'h0;
    s_nxt    = s_r;
    if (!run) begin
      s_nxt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
      if (s_r.cnt == 8'hff) begin
        s_nxt.slot = (s_r.slot == 2'h2) ? 2'h0 : s_r.slot + 2'h1;
      end
      duty_on  = (s_r.cnt <= {luminance_level, 5'h1f});
      // without overlap each colour owns one slot of three
      slot_sel = 3'h4 >> s_r.slot;
      s_nxt.pwm = tint_mix(tint) & {3{duty_on}} & (overlap_mode ? 3'h7 : slot_sel);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm = s_r.pwm;
endmodule
`default_nettype wire

// file: lcr_fade.sv
// automatic fade ramp of one backlight current code
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.svh"
module lcr_fade #(
  parameter int unsigned STEP_SHORT = `LCR_FADE_SHORT_CYC,
  parameter int unsigned STEP_LONG  = `LCR_FADE_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       long_sel,
  input  wire logic [7:0] target,
  output logic      [7:0] level
);
  import lcr_pkg::*;

  localparam logic [`LCR_FADE_CNT_W-1:0] LAST_SHORT = `LCR_FADE_CNT_W'(STEP_SHORT - 1);
  localparam logic [`LCR_FADE_CNT_W-1:0] LAST_LONG  = `LCR_FADE_CNT_W'(STEP_LONG - 1);

  lcr_fade_s s_r;
  lcr_fade_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!enable) begin
      s_nxt.st    = LCR_FADE_IDLE;
      s_nxt.cnt   = '0;
      s_nxt.level = target;
    end else begin
      unique case (s_r.st)
        LCR_FADE_IDLE: begin
          s_nxt.cnt = '0;
          if (s_r.level != target) begin
            s_nxt.st = LCR_FADE_RAMP;
          end
        end
        LCR_FADE_RAMP: begin
          if (s_r.level == target) begin
            s_nxt.st = LCR_FADE_IDLE;
          end else if (s_r.cnt >= (long_sel ? LAST_LONG : LAST_SHORT)) begin
            s_nxt.cnt   = '0;
            s_nxt.level = (s_r.level < target) ? s_r.level + 8'h01 : s_r.level - 8'h01;
          end else begin
            s_nxt.cnt = s_r.cnt + `LCR_FADE_CNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.level;
endmodule
`default_nettype wire

// file: lcr_regbank.sv
// lighting control register bank top
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.svh"
module lcr_regbank #(
  parameter int unsigned FADE_STEP_SHORT = `LCR_FADE_SHORT_CYC,
  parameter int unsigned FADE_STEP_LONG  = `LCR_FADE_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rdata_valid,
  input  wire logic       safety_active_in,
  input  wire logic       ext_pwm_in,
  input  wire logic [2:0] gpio_in,
  output logic      [2:0] gpio_out,
  output logic      [2:0] gpio_oe,
  output logic            red_led_out,
  output logic            green_led_out,
  output logic            blue_led_out,
  output logic            output_type_select,
  output logic      [1:0] red_current_limit,
  output logic      [1:0] green_current_limit,
  output logic      [1:0] blue_current_limit,
  output logic      [7:0] main_current_code,
  output logic      [7:0] sub_current_code,
  output logic            ext_pwm_gate,
  output logic            active_not_standby,
  output logic            boost_enable_out,
  output logic            flash_enable_out,
  output logic            active_load_enable
);
  import lcr_pkg::*;

  lcr_top_s s_r;
  lcr_top_s s_nxt;

  logic [2:0] pwm_bits;
  logic [7:0] fade_level;
  logic [7:0] main_eff;
  logic [7:0] sub_eff;
  logic [7:0] fade_target;
  logic       fade_on_sub;
  logic       safety_r;

  // ***********************************
  // address decode
  // ***********************************
  // mask of writable bits for an offset; zero for unmapped addresses
  function automatic logic [7:0] write_mask(input logic [7:0] a);
    unique case (a)
      `LCR_OFS_COLOR_CTRL: write_mask = `LCR_WM_COLOR_CTRL;
      `LCR_OFS_TINT_LUMA:  write_mask = `LCR_WM_FULL;
      `LCR_OFS_CUR_LIMITS: write_mask = `LCR_WM_CUR_LIMITS;
      `LCR_OFS_WHITE_CTRL: write_mask = `LCR_WM_WHITE_CTRL;
      `LCR_OFS_MAIN_CUR:   write_mask = `LCR_WM_FULL;
      `LCR_OFS_SUB_CUR:    write_mask = `LCR_WM_FULL;
      `LCR_OFS_PIN_DIR:    write_mask = `LCR_WM_PIN_DIR;
      `LCR_OFS_PIN_DATA:   write_mask = `LCR_WM_PIN_DATA;
      `LCR_OFS_POWER_EN:   write_mask = `LCR_WM_POWER_EN;
      default:             write_mask = `LCR_RST_ZERO;
    endcase
  endfunction

  // masked write keeps read-only bits at their stored zero
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ***********************************
  // colour pwm and fade engines
  // ***********************************
  lcr_color_pwm u_pwm (
    .clk             (clk),
    .rst_n           (rst_n),
    .run             (s_r.color_ctrl[`LCR_B_PWM_EN] & s_r.power_en[`LCR_B_ACTIVE]),
    .tint            (s_r.tint_luma[7:4]),
    .luminance_level (s_r.tint_luma[3:1]),
    .overlap_mode    (s_r.tint_luma[0]),
    .pwm             (pwm_bits)
  );

  always_comb begin
    // ganged strings both follow the primary code
    main_eff    = s_r.main_cur;
    sub_eff     = s_r.white_ctrl[`LCR_B_GANG] ? s_r.main_cur : s_r.sub_cur;
    fade_on_sub = s_r.white_ctrl[`LCR_B_FADE_SUB];
    fade_target = fade_on_sub ? sub_eff : main_eff;
  end

  lcr_fade #(
    .STEP_SHORT (FADE_STEP_SHORT),
    .STEP_LONG  (FADE_STEP_LONG)
  ) u_fade (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (s_r.white_ctrl[`LCR_B_FADE_EN]),
    .long_sel (s_r.white_ctrl[`LCR_B_FADE_LONG]),
    .target   (fade_target),
    .level    (fade_level)
  );

  // ***********************************
  // safety status
  // ***********************************
  // plain registered level; clears one cycle after safety_active_in drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safety_r <= 1'b0;
    end else begin
      safety_r <= safety_active_in;
    end
  end

  // ***********************************
  // register file and output logic
  // ***********************************
  always_comb begin
    logic [7:0] m;
    logic       act;
    logic       master;
    logic [2:0] chan_en;
    logic [2:0] drive;
    logic [7:0] main_str;
    logic [7:0] sub_str;
    m        = write_mask(reg_addr);
    act      = 1'b0;
    master   = 1'b0;
    chan_en  = 3'h0;
    drive    = 3'h0;
    main_str = 8'h00;
    sub_str  = 8'h00;
    s_nxt    = s_r;
    s_nxt.rvalid = 1'b0;

    if (reg_wr) begin
      unique case (reg_addr)
        `LCR_OFS_COLOR_CTRL: s_nxt.color_ctrl = merge(s_r.color_ctrl, reg_wdata, m);
        `LCR_OFS_TINT_LUMA:  s_nxt.tint_luma  = merge(s_r.tint_luma, reg_wdata, m);
        `LCR_OFS_CUR_LIMITS: s_nxt.cur_limits = merge(s_r.cur_limits, reg_wdata, m);
        `LCR_OFS_WHITE_CTRL: s_nxt.white_ctrl = merge(s_r.white_ctrl, reg_wdata, m);
        `LCR_OFS_MAIN_CUR:   s_nxt.main_cur   = merge(s_r.main_cur, reg_wdata, m);
        `LCR_OFS_SUB_CUR:    s_nxt.sub_cur    = merge(s_r.sub_cur, reg_wdata, m);
        `LCR_OFS_PIN_DIR:    s_nxt.pin_dir    = merge(s_r.pin_dir, reg_wdata, m);
        `LCR_OFS_PIN_DATA:   s_nxt.pin_data   = merge(s_r.pin_data, reg_wdata, m);
        `LCR_OFS_POWER_EN:   s_nxt.power_en   = merge(s_r.power_en, reg_wdata, m);
        default: ;
      endcase
    end

    // read sees the value before a write in the same cycle
    if (reg_rd) begin
      s_nxt.rvalid = 1'b1;
      unique case (reg_addr)
        `LCR_OFS_COLOR_CTRL: s_nxt.rdata = s_r.color_ctrl;
        `LCR_OFS_TINT_LUMA:  s_nxt.rdata = s_r.tint_luma;
        `LCR_OFS_CUR_LIMITS: s_nxt.rdata = {safety_r, s_r.cur_limits[6:0]};
        `LCR_OFS_WHITE_CTRL: s_nxt.rdata = s_r.white_ctrl;
        `LCR_OFS_MAIN_CUR:   s_nxt.rdata = s_r.main_cur;
        `LCR_OFS_SUB_CUR:    s_nxt.rdata = s_r.sub_cur;
        `LCR_OFS_PIN_DIR:    s_nxt.rdata = s_r.pin_dir;
        // input pins read back their level, output pins their data bit
        `LCR_OFS_PIN_DATA:   s_nxt.rdata = {5'h00,
                                            (s_r.pin_dir[2:0] & s_r.pin_data[2:0]) |
                                            (~s_r.pin_dir[2:0] & gpio_in)};
        `LCR_OFS_POWER_EN:   s_nxt.rdata = s_r.power_en;
        default:             s_nxt.rdata = `LCR_RST_ZERO;
      endcase
    end

    act     = s_r.power_en[`LCR_B_ACTIVE];
    master  = s_r.color_ctrl[`LCR_B_MASTER_EN];
    chan_en = {s_r.color_ctrl[`LCR_B_RED_EN],
               s_r.color_ctrl[`LCR_B_GREEN_EN],
               s_r.color_ctrl[`LCR_B_BLUE_EN]};
    // pwm bits only matter while internal pwm runs; otherwise steady on
    drive   = s_r.color_ctrl[`LCR_B_PWM_EN] ? pwm_bits : 3'h7;
    s_nxt.led = drive & chan_en & {3{master & act}};

    // faded string takes the ramp level, the other its code directly
    main_str = (s_r.white_ctrl[`LCR_B_FADE_EN] && !fade_on_sub) ? fade_level : main_eff;
    sub_str  = (s_r.white_ctrl[`LCR_B_FADE_EN] && fade_on_sub) ? fade_level : sub_eff;
    s_nxt.main_code = (act && s_r.white_ctrl[`LCR_B_MAIN_EN]) ? main_str : 8'h00;
    s_nxt.sub_code  = (act && s_r.white_ctrl[`LCR_B_SUB_EN]) ? sub_str : 8'h00;

    s_nxt.gpio_oe  = s_r.pin_dir[2:0];
    s_nxt.gpio_out = s_r.pin_data[2:0] & s_r.pin_dir[2:0];
    s_nxt.ext_gate = s_r.pin_dir[`LCR_B_EXT_PWM_EN] & ext_pwm_in;
  end

  // ***********************************
  // state register
  // ***********************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r            <= '0;
      s_r.color_ctrl <= `LCR_RST_COLOR_CTRL;
      s_r.power_en   <= `LCR_RST_POWER_EN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***********************************
  // outputs, all from flip-flops
  // ***********************************
  assign reg_rdata           = s_r.rdata;
  assign reg_rdata_valid     = s_r.rvalid;
  assign gpio_out            = s_r.gpio_out;
  assign gpio_oe             = s_r.gpio_oe;
  assign red_led_out         = s_r.led[2];
  assign green_led_out       = s_r.led[1];
  assign blue_led_out        = s_r.led[0];
  assign output_type_select  = s_r.color_ctrl[`LCR_B_OUT_TYPE];
  assign red_current_limit   = s_r.cur_limits[5:4];
  assign green_current_limit = s_r.cur_limits[3:2];
  assign blue_current_limit  = s_r.cur_limits[1:0];
  assign main_current_code   = s_r.main_code;
  assign sub_current_code    = s_r.sub_code;
  assign ext_pwm_gate        = s_r.ext_gate;
  assign active_not_standby  = s_r.power_en[`LCR_B_ACTIVE];
  // boost, flash and load mirror their bits even in standby; gating is analog-side
  assign boost_enable_out    = s_r.power_en[`LCR_B_BOOST];
  assign flash_enable_out    = s_r.power_en[`LCR_B_FLASH];
  assign active_load_enable  = s_r.power_en[`LCR_B_LOAD];
endmodule
`default_nettype wire

// file: lcr_host_model.sv
// host side model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle strobes, changed on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not look like the last value
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      ok = (reg_rdata_valid === 1'b1);
      d = reg_rdata;
      if (!ok) @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: lcr_regbank_asserts.sv
// concurrent checks on the ports of the register bank
`timescale 1ns/1ps
`default_nettype none
module lcr_regbank_asserts #(
  parameter int unsigned FADE_STEP_SHORT = 4,
  parameter int unsigned FADE_STEP_LONG  = 8
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rdata_valid,
  input wire logic       safety_active_in,
  input wire logic       ext_pwm_in,
  input wire logic [2:0] gpio_oe,
  input wire logic       red_led_out,
  input wire logic       green_led_out,
  input wire logic       blue_led_out,
  input wire logic       output_type_select,
  input wire logic [7:0] main_current_code,
  input wire logic [7:0] sub_current_code,
  input wire logic       ext_pwm_gate,
  input wire logic       active_not_standby,
  input wire logic       active_load_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reset_state_a: assert property (
    $rose(rst_n) |-> output_type_select && active_load_enable && !active_not_standby)
    else $error("outputs off reset values after release");
  safety_read_a: assert property (
    reg_rd && reg_addr == 8'h02 |=> reg_rdata[7] == $past(safety_active_in, 2))
    else $error("safety bit read wrong");
  pin_data_zero_a: assert property (
    reg_rd && reg_addr == 8'h07 |=> reg_rdata_valid && reg_rdata[7:3] == 5'h00)
    else $error("pin data upper bits not zero");
  ctrl_reserved_a: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0)
    else $error("reserved colour bits not zero");
  pin_dir_a: assert property (
    reg_wr && reg_addr == 8'h06 |-> ##2 gpio_oe == $past(reg_wdata[2:0], 2))
    else $error("pin direction not applied");
  otype_write_a: assert property (
    reg_wr && reg_addr == 8'h00 |=> output_type_select == $past(reg_wdata[5]))
    else $error("output type not applied");
  standby_dark_a: assert property (
    !$past(active_not_standby) |-> !(red_led_out || green_led_out || blue_led_out)
      && main_current_code == 8'h00 && sub_current_code == 8'h00)
    else $error("outputs live in standby");
  ext_gate_a: assert property (
    ext_pwm_gate |-> $past(ext_pwm_in))
    else $error("external gate without pin level");

  cover property (reg_rd && reg_addr == 8'h02 && safety_active_in);
  cover property (reg_wr && reg_addr == 8'h06);
  cover property (ext_pwm_gate);
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the lighting control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lcr_pkg::*;
  // writable masks and reset values, offset 0 in the low byte
  localparam logic [71:0] WM = 72'h6c_07_17_ff_ff_3f_3f_ff_ee;
  localparam logic [71:0] RV = 72'h04_00_00_00_00_00_00_00_20;
  // colour mix per tint code 0..5, red in bit 2
  localparam logic [17:0] TINT = 18'b101_011_110_001_010_100;
  logic        clk, rst_n, reg_wr, reg_rd, reg_rdata_valid, safety_active_in, ext_pwm_in;
  logic        red_led_out, green_led_out, blue_led_out, output_type_select, ext_pwm_gate;
  logic        active_not_standby, boost_enable_out, flash_enable_out, active_load_enable;
  logic [1:0]  red_current_limit, green_current_limit, blue_current_limit;
  logic [2:0]  gpio_in, gpio_out, gpio_oe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, main_current_code, sub_current_code;
  logic [7:0]  m [0:8];
  logic [31:0] lfsr;
  int          mismatches = 0;
  int          compares = 0;

  // short fade steps keep a ramp within a few dozen cycles
  lcr_regbank #(.FADE_STEP_SHORT(4), .FADE_STEP_LONG(8)) i_dut (.*);
  lcr_host_model i_host (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d);
    if (a < 8'd9) m[a] = (m[a] & ~WM[a*8 +: 8]) | (d & WM[a*8 +: 8]);
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d, e;
    bit         ok;
    i_host.rd(a, d, ok);
    e = (a > 8'd8) ? 8'h00 : m[a];
    if (a == 8'h02) e[7] = safety_active_in;
    if (a == 8'h07) e[2:0] = (m[7][2:0] & m[6][2:0]) | (gpio_in & ~m[6][2:0]);
    chk($sformatf("reg %h", a), {15'h0, 1'b1, e}, {15'h0, ok, d});
  endtask

  task automatic chk_outs();
    logic [23:0] e, g;
    e = {6'h0, m[6][2:0], m[7][2:0] & m[6][2:0], m[2][5:0], m[8][6:5], m[8][3:2], m[0][5],
         m[6][4] & ext_pwm_in};
    g = {6'h0, gpio_oe, gpio_out, red_current_limit, green_current_limit, blue_current_limit,
         active_not_standby, boost_enable_out, flash_enable_out, active_load_enable,
         output_type_select, ext_pwm_gate};
    chk("pins", e, g);
    g = {21'h0, red_led_out, green_led_out, blue_led_out};
    e = {21'h0, m[0][3:1] & {3{m[0][6] & m[8][6]}}};
    if (!m[0][7]) chk("leds", e, g);
    g = {8'h0, main_current_code, sub_current_code};
    e = {8'h0, m[4] & {8{m[8][6] & m[3][1]}}, (m[3][2] ? m[4] : m[5]) & {8{m[8][6] & m[3][0]}}};
    if (!m[3][3]) chk("codes", e, g);
  endtask

  task automatic do_reset();
    int i;
    rst_n = 1'b0;
    for (i = 0; i < 9; i++) m[i] = RV[i*8 +: 8];
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 10; i++) rd_chk(i[7:0]);
    chk_outs();
  endtask

  initial begin
    logic [7:0]  a, d;
    int          n;
    logic [23:0] on_all, on_red;
    safety_active_in = 1'b0;
    ext_pwm_in = 1'b0;
    gpio_in = 3'h5;
    lfsr = 32'h7dbec9ab;
    do_reset();
    for (n = 0; n < 80; n++) begin
      lfsr = nxt(nxt(nxt(lfsr)));
      a = (lfsr[3:0] > 4'd9) ? 8'hff : {4'h0, lfsr[3:0]};
      d = lfsr[15:8];
      if (a == 8'h03) d[3] = 1'b0; // no ramp here, so codes follow writes at once
      ext_pwm_in = lfsr[20];
      gpio_in = lfsr[23:21];
      hw(a, d);
      repeat (2) @(negedge clk);
      chk_outs();
      rd_chk(a);
    end
    safety_active_in = 1'b1;
    ext_pwm_in = 1'b1;
    hw(8'h02, 8'hff);
    hw(8'h06, 8'h17);
    hw(8'h07, 8'hff);
    hw(8'h08, 8'hff);
    hw(8'h00, 8'hff);
    repeat (2) @(negedge clk);
    chk_outs();
    for (n = 0; n < 9; n++) rd_chk(n[7:0]);
    for (n = 0; n < 6; n++) begin
      hw(8'h01, {n[3:0], 4'he});
      repeat (4) @(negedge clk);
      d = 8'h00;
      repeat (800) begin
        @(negedge clk);
        d[2:0] = d[2:0] | {red_led_out, green_led_out, blue_led_out};
      end
      chk("tint", {21'h0, TINT[n*3 +: 3]}, {16'h0, d});
    end
    // level 0: on for 32 of 256 counts; 768 cycles hold every slot and count once
    for (n = 0; n < 2; n++) begin
      hw(8'h01, {7'h30, ~n[0]});
      repeat (4) @(negedge clk);
      on_all = 24'h0;
      on_red = 24'h0;
      repeat (768) begin
        @(negedge clk);
        on_all = on_all + {23'h0, red_led_out & green_led_out & blue_led_out};
        on_red = on_red + {23'h0, red_led_out};
      end
      chk("overlap", n[0] ? 24'd0 : 24'd96, on_all);
      chk("level", n[0] ? 24'd32 : 24'd96, on_red);
    end
    // third pass fades the secondary string
    for (n = 0; n < 3; n++) begin
      hw(8'h03, 8'h03);
      hw(8'h04, 8'h00);
      hw(8'h05, 8'h00);
      hw(8'h03, {2'h0, n[0], n[1], 4'hb});
      hw(n[1] ? 8'h05 : 8'h04, 8'h0a);
      repeat (2) @(negedge clk);
      d = n[1] ? sub_current_code : main_current_code;
      chk("ramp", 24'h1, {23'h0, d < 8'h0a});
      repeat (50) @(negedge clk);
      d = n[1] ? sub_current_code : main_current_code;
      chk("fade", {23'h0, ~n[0]}, {23'h0, d == 8'h0a});
    end
    do_reset();
    tally_and_finish();
  end
endmodule

bind lcr_regbank lcr_regbank_asserts #(.FADE_STEP_SHORT(FADE_STEP_SHORT),
  .FADE_STEP_LONG(FADE_STEP_LONG)) i_chk (.*);
`default_nettype wire
